// ---- rtl/nvmp_dmap.sv ----
// Data-space address decoder for I/O, mapped EEPROM and SRAM.
`timescale 1ns/100ps
`default_nettype none
`include "nvmp_map.svh"
module nvmp_dmap (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Access
  input  wire logic        dm_valid,
  input  wire logic        dm_write,
  input  wire logic [15:0] dm_addr,
  input  wire logic        mm_en,
  // Decode result
  output logic      [3:0]  region,
  output logic      [4:0]  eep_byte,
  output logic      [6:0]  eep_page,
  output logic             wr_drop
);
  import nvmp_pkg::*;
  nvmp_dmap_s st_reg;
  nvmp_dmap_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.wr_drop = 1'b0;
    if (dm_valid) begin
      if (dm_addr <= `NVMP_IO_TOP) begin
        st_next.region = 4'h1;
      end else if (dm_addr <= `NVMP_EEP_TOP) begin
        st_next.region = mm_en ? 4'h2 : 4'h8;
      end else if (dm_addr <= `NVMP_SRAM_TOP) begin
        st_next.region = 4'h4;
      end else begin
        st_next.region = 4'h8;
      end
      st_next.eep_byte = dm_addr[`NVMP_EBYTE_MSB:0];
      st_next.eep_page = dm_addr[`NVMP_EPAGE_MSB:`NVMP_EPAGE_LSB];
      st_next.wr_drop  = dm_write & st_next.region[3];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign region   = st_reg.region;
  assign eep_byte = st_reg.eep_byte;
  assign eep_page = st_reg.eep_page;
  assign wr_drop  = st_reg.wr_drop;
endmodule
`default_nettype wire

// ---- rtl/nvmp_map.svh ----
// Offsets, map limits, fields and reset values of the NVM protection block.
`ifndef NVMP_MAP_SVH
`define NVMP_MAP_SVH
`define NVMP_OFF_CTRL     8'h00
`define NVMP_OFF_LOCK     8'h04
`define NVMP_OFF_FUSE     8'h08
`define NVMP_OFF_CMD      8'h0C
`define NVMP_OFF_STAT     8'h10
`define NVMP_OFF_UADDR    8'h14
`define NVMP_OFF_UDATA    8'h18
`define NVMP_OFF_PADDR    8'h1C
`define NVMP_OFF_PDATA    8'h20
`define NVMP_CTRL_MM      0
`define NVMP_CMD_CHIP     0
`define NVMP_CMD_USIG     1
`define NVMP_LOCK_RST     6'h3F
`define NVMP_FUSE_RST     8'hFF
`define NVMP_RESP_OK      2'h0
`define NVMP_RESP_ERR     2'h2
`define NVMP_APP_TOP      18'h1_EFFF
`define NVMP_TBL_BASE     18'h1_F000
`define NVMP_BOOT_BASE    18'h2_0000
`define NVMP_BOOT_TOP     18'h2_0FFF
`define NVMP_FLASH_WORD_IN_PAGE_MSB    8
`define NVMP_FLASH_WORD_IN_PAGE_LSB    1
`define NVMP_FLASH_PAGE_NUMBER_MSB    18
`define NVMP_FLASH_PAGE_NUMBER_LSB    9
`define NVMP_IO_TOP       16'h0FFF
`define NVMP_EEP_TOP      16'h1FFF
`define NVMP_SRAM_TOP     16'h5FFF
`define NVMP_EBYTE_MSB    4
`define NVMP_EPAGE_MSB    11
`define NVMP_EPAGE_LSB    5
`define NVMP_PSIG_CAL     3'h4
`define NVMP_USIG_WORDS   256
`endif

// ---- rtl/nvmp_pkg.sv ----
// Types shared by the NVM protection block.
package nvmp_pkg;
  typedef logic [15:0] nvmp_word_t;
  typedef enum logic [1:0] {
    NVMP_SEC_APP  = 2'h0,
    NVMP_SEC_TBL  = 2'h1,
    NVMP_SEC_BOOT = 2'h2,
    NVMP_SEC_NONE = 2'h3
  } nvmp_sec_e;
  typedef enum logic [4:0] {
    NVMP_ST_CAL0  = 5'h01,
    NVMP_ST_CAL1  = 5'h02,
    NVMP_ST_IDLE  = 5'h04,
    NVMP_ST_ERASE = 5'h08,
    NVMP_ST_LCLR  = 5'h10
  } nvmp_state_e;
  typedef struct packed {
    nvmp_state_e st;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rpend;
    logic [7:0]  ar_addr;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        mm_en;
    logic [5:0]  lock;
    logic [7:0]  fuse;
    logic [7:0]  usig_addr;
    logic [2:0]  psig_addr;
    nvmp_word_t  calib;
    logic        fl_grant;
    logic        fl_deny;
    nvmp_sec_e   fl_sec;
    logic [7:0]  fl_word;
    logic [9:0]  fl_page;
    nvmp_word_t  fl_wdata;
    logic        erase_req;
    logic        last_deny;
  } nvmp_top_s;
  typedef struct packed {
    logic [3:0] region;
    logic [4:0] eep_byte;
    logic [6:0] eep_page;
    logic       wr_drop;
  } nvmp_dmap_s;
  typedef struct packed {
    logic [255:0][15:0] usig;
    nvmp_word_t         urd;
    nvmp_word_t         prd;
  } nvmp_sig_s;
endpackage

// ---- rtl/nvmp_sig_if.sv ----
// Connection between the protection core and its signature row store.
`timescale 1ns/100ps
`default_nettype none
interface nvmp_sig_if;
  logic [7:0]  usig_addr;
  logic [15:0] usig_wdata;
  logic        usig_we;
  logic        usig_erase;
  logic [2:0]  psig_addr;
  logic [15:0] usig_rdata;
  logic [15:0] psig_rdata;
  modport core (output usig_addr, usig_wdata, usig_we, usig_erase, psig_addr,
                input usig_rdata, psig_rdata);
  modport mem  (input usig_addr, usig_wdata, usig_we, usig_erase, psig_addr,
                output usig_rdata, psig_rdata);
endinterface
`default_nettype wire

// ---- rtl/nvmp_sigrow.sv ----
// Signature rows: writable user row, read-only production row.
`timescale 1ns/100ps
`default_nettype none
`include "nvmp_map.svh"
module nvmp_sigrow #(
  parameter logic [15:0] DEV_ID   = 16'h5A_A5, // Arbitrary value.
  parameter logic [15:0] LOT_NUM  = 16'h0000,
  parameter logic [7:0]  WAFER    = 8'h00,
  parameter logic [7:0]  COORD_X  = 8'h00,
  parameter logic [7:0]  COORD_Y  = 8'h00,
  parameter logic [15:0] CAL_WORD = 16'h0080
) (
  // Clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   clk_en,
  // Core side
  nvmp_sig_if.mem     sig
);
  import nvmp_pkg::*;
  nvmp_sig_s st_reg;
  nvmp_sig_s st_next;

  function automatic nvmp_word_t prod_rom(input logic [2:0] idx);
    case (idx)
      3'h0:    prod_rom = DEV_ID;
      3'h1:    prod_rom = LOT_NUM;
      3'h2:    prod_rom = {WAFER, COORD_X};
      3'h3:    prod_rom = {COORD_Y, 8'h00};
      3'h4:    prod_rom = CAL_WORD;
      default: prod_rom = 16'hFFFF;
    endcase
  endfunction

  always_comb begin
    st_next = st_reg;
    if (sig.usig_erase) begin
      for (int i = 0; i < `NVMP_USIG_WORDS; i++) begin
        st_next.usig[i] = 16'hFFFF;
      end
    end else if (sig.usig_we) begin
      st_next.usig[sig.usig_addr] = sig.usig_wdata;
    end
    st_next.urd = st_reg.usig[sig.usig_addr];
    // Production row has no write path.
    st_next.prd = prod_rom(sig.psig_addr);
  end

  // Rows are nonvolatile; reset clears only the read registers.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg.urd <= 16'h0000;
      st_reg.prd <= 16'h0000;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign sig.usig_rdata = st_reg.urd;
  assign sig.psig_rdata = st_reg.prd;
endmodule
`default_nettype wire

// ---- rtl/nvmp_top.sv ----
// NVM protection core: flash locks, fuses, signature rows, AXI4-Lite registers.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "nvmp_map.svh"
module nvmp_top (
  // Clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // AXI4-Lite write
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic      [1:0]           s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  // Access source
  input  wire logic                 ext_prog_active,
  // Flash access check
  input  wire logic                 fl_req_valid,
  input  wire logic                 fl_req_write,
  input  wire logic [18:0]          fl_z_ptr,
  input  wire logic [17:0]          fl_exec_pc,
  input  wire nvmp_pkg::nvmp_word_t fl_req_wdata,
  output logic                      fl_grant,
  output logic                      fl_deny,
  output nvmp_pkg::nvmp_sec_e       fl_section,
  output logic      [7:0]           flash_word_in_page,
  output logic      [9:0]           flash_page_number,
  output nvmp_pkg::nvmp_word_t      fl_wdata,
  // Chip erase handshake with flash array
  output logic                      chip_erase_req,
  input  wire logic                 chip_erase_done,
  // Calibration and configuration
  output nvmp_pkg::nvmp_word_t      calib_value,
  output logic      [7:0]           fuse_value,
  output logic      [5:0]           lock_value,
  output logic                      eeprom_mapped,
  // Data-space decode
  input  wire logic                 dm_valid,
  input  wire logic                 dm_write,
  input  wire logic [15:0]          dm_addr,
  output logic      [3:0]           dm_region,
  output logic      [4:0]           eeprom_byte_in_page,
  output logic      [6:0]           eeprom_page_number,
  output logic                      dm_write_dropped
);
  import nvmp_pkg::*;

  nvmp_top_s st_reg;
  nvmp_top_s st_next;
  nvmp_sig_if sig ();

  logic       wr_fire;
  logic       usig_we;
  logic       usig_erase;
  nvmp_sec_e  req_sec;
  nvmp_sec_e  pc_sec;
  logic       w_ok;
  logic       r_ok;
  logic       ok;

  // Table section is sized like boot.
  function automatic nvmp_sec_e sec_of(input logic [17:0] wa);
    if (wa <= `NVMP_APP_TOP) begin
      sec_of = NVMP_SEC_APP;
    end else if (wa < `NVMP_BOOT_BASE) begin
      sec_of = NVMP_SEC_TBL;
    end else if (wa <= `NVMP_BOOT_TOP) begin
      sec_of = NVMP_SEC_BOOT;
    end else begin
      sec_of = NVMP_SEC_NONE;
    end
  endfunction

  function automatic logic known_reg(input logic [7:0] a);
    // Registers fill every aligned word from CTRL up to PDATA.
    known_reg = (a <= `NVMP_OFF_PDATA) && (a[1:0] == 2'h0);
  endfunction

  always_comb begin
    st_next   = st_reg;
    usig_we   = 1'b0;
    usig_erase = 1'b0;

    // Write channel capture in either order.
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    wr_fire = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;

    if (wr_fire) begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = known_reg(st_reg.aw_addr) ? `NVMP_RESP_OK : `NVMP_RESP_ERR;
      // Only byte lane 0 carries control fields; of the upper lanes only lane 1 matters, for the UDATA word.
      if (st_reg.w_strb[0]) begin
        case (st_reg.aw_addr)
          `NVMP_OFF_CTRL: begin
            st_next.mm_en = st_reg.w_data[`NVMP_CTRL_MM];
          end
          `NVMP_OFF_LOCK: begin
            st_next.lock = st_reg.lock & st_reg.w_data[5:0];
          end
          `NVMP_OFF_FUSE: begin
            if (ext_prog_active) begin
              st_next.fuse = st_reg.w_data[7:0];
            end
          end
          `NVMP_OFF_CMD: begin
            if (st_reg.w_data[`NVMP_CMD_CHIP] && st_reg.st == NVMP_ST_IDLE) begin
              st_next.st = NVMP_ST_ERASE;
            end
            usig_erase = st_reg.w_data[`NVMP_CMD_USIG];
          end

          `NVMP_OFF_UADDR: begin
            st_next.usig_addr = st_reg.w_data[7:0];
          end

          `NVMP_OFF_UDATA: begin
            usig_we = st_reg.w_strb[1];
          end

          `NVMP_OFF_PADDR: begin
            st_next.psig_addr = st_reg.w_data[2:0];
          end

          default: begin
          end

        endcase
      end
    end

    // Read path: one cycle to settle signature row data, one to answer.
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rpend   = 1'b1;
      st_next.ar_addr = s_axi_araddr;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (st_reg.rpend) begin
      st_next.rpend  = 1'b0;
      st_next.rvalid = 1'b1;
      st_next.rresp  = known_reg(st_reg.ar_addr) ? `NVMP_RESP_OK : `NVMP_RESP_ERR;
      case (st_reg.ar_addr)
        `NVMP_OFF_CTRL:  st_next.rdata = {31'h0, st_reg.mm_en};
        `NVMP_OFF_LOCK:  st_next.rdata = {26'h0, st_reg.lock};
        `NVMP_OFF_FUSE:  st_next.rdata = {24'h0, st_reg.fuse};
        `NVMP_OFF_STAT:  st_next.rdata = {26'h0, st_reg.last_deny, st_reg.st};
        `NVMP_OFF_UADDR: st_next.rdata = {24'h0, st_reg.usig_addr};
        `NVMP_OFF_UDATA: st_next.rdata = {16'h0, sig.usig_rdata};
        `NVMP_OFF_PADDR: st_next.rdata = {29'h0, st_reg.psig_addr};
        `NVMP_OFF_PDATA: st_next.rdata = {16'h0, sig.psig_rdata};
        default:         st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Flash access check.
    req_sec = sec_of(fl_z_ptr[`NVMP_FLASH_PAGE_NUMBER_MSB:`NVMP_FLASH_WORD_IN_PAGE_LSB]);
    pc_sec  = sec_of(fl_exec_pc);
    w_ok = (ext_prog_active || pc_sec == NVMP_SEC_BOOT)
         && st_reg.lock[{req_sec, 1'b0}];
    r_ok = st_reg.lock[{req_sec, 1'b1}];
    ok   = (req_sec != NVMP_SEC_NONE) && (st_reg.st == NVMP_ST_IDLE)
         && (fl_req_write ? w_ok : r_ok);
    st_next.fl_grant = fl_req_valid && ok;
    st_next.fl_deny  = fl_req_valid && !ok;
    if (fl_req_valid) begin
      st_next.last_deny = !ok;
      st_next.fl_sec    = req_sec;
      st_next.fl_word   = fl_z_ptr[`NVMP_FLASH_WORD_IN_PAGE_MSB:`NVMP_FLASH_WORD_IN_PAGE_LSB];
      st_next.fl_page   = fl_z_ptr[`NVMP_FLASH_PAGE_NUMBER_MSB:`NVMP_FLASH_PAGE_NUMBER_LSB];
      st_next.fl_wdata  = fl_req_wdata;
    end

    // Sequencer for calibration load and chip erase.
    case (st_reg.st)
      NVMP_ST_CAL0: begin
        st_next.st = NVMP_ST_CAL1;
      end

      NVMP_ST_CAL1: begin
        st_next.calib = sig.psig_rdata;
        st_next.st    = NVMP_ST_IDLE;
      end

      NVMP_ST_IDLE: begin
        st_next.erase_req = 1'b0;
      end

      NVMP_ST_ERASE: begin
        st_next.erase_req = 1'b1;
        if (chip_erase_done) begin
          st_next.erase_req = 1'b0;
          st_next.st        = NVMP_ST_LCLR;
        end
      end

      NVMP_ST_LCLR: begin
        // Locks released only after flash erase.
        st_next.lock = `NVMP_LOCK_RST;
        st_next.st   = NVMP_ST_IDLE;
      end

      default: begin
        st_next.st = NVMP_ST_IDLE;
      end
    endcase

    // One write and one read in flight at a time.
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready  = !st_next.w_have && !st_next.bvalid;
    st_next.arready = !st_next.rpend && !st_next.rvalid;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.st      <= NVMP_ST_CAL0;
      st_reg.lock    <= `NVMP_LOCK_RST;
      st_reg.fuse    <= `NVMP_FUSE_RST;
      st_reg.fl_sec  <= NVMP_SEC_NONE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign sig.usig_addr  = st_reg.usig_addr;
  assign sig.usig_wdata = st_reg.w_data[15:0];
  assign sig.usig_we    = usig_we;
  assign sig.usig_erase = usig_erase;
  assign sig.psig_addr  = (st_reg.st == NVMP_ST_CAL0) ? `NVMP_PSIG_CAL
                        : st_reg.psig_addr;

  nvmp_sigrow u_sigrow (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .sig      (sig.mem)
  );

  nvmp_dmap u_dmap (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .dm_valid (dm_valid),
    .dm_write (dm_write),
    .dm_addr  (dm_addr),
    .mm_en    (st_reg.mm_en),
    .region   (dm_region),
    .eep_byte (eeprom_byte_in_page),
    .eep_page (eeprom_page_number),
    .wr_drop  (dm_write_dropped)
  );

  assign s_axi_awready      = st_reg.awready;
  assign s_axi_wready       = st_reg.wready;
  assign s_axi_bvalid       = st_reg.bvalid;
  assign s_axi_bresp        = st_reg.bresp;
  assign s_axi_arready      = st_reg.arready;
  assign s_axi_rvalid       = st_reg.rvalid;
  assign s_axi_rdata        = st_reg.rdata;
  assign s_axi_rresp        = st_reg.rresp;
  assign fl_grant           = st_reg.fl_grant;
  assign fl_deny            = st_reg.fl_deny;
  assign fl_section         = st_reg.fl_sec;
  assign flash_word_in_page = st_reg.fl_word;
  assign flash_page_number  = st_reg.fl_page;
  assign fl_wdata           = st_reg.fl_wdata;
  assign chip_erase_req     = st_reg.erase_req;
  assign calib_value        = st_reg.calib;
  assign fuse_value         = st_reg.fuse;
  assign lock_value         = st_reg.lock;
  assign eeprom_mapped      = st_reg.mm_en;
endmodule
`default_nettype wire

// ---- testbench/nvmp_checker.sv ----
// Assertion checker for the NVM protection core.
`timescale 1ns/100ps
`default_nettype none
module nvmp_checker (
  // Clock and reset
  input wire logic                core_clk,
  input wire logic                rst_n,
  // Flash check
  input wire logic                ext_prog_active,
  input wire logic                fl_req_valid,
  input wire logic                fl_req_write,
  input wire logic [18:0]         fl_z_ptr,
  input wire logic [17:0]         fl_exec_pc,
  input wire logic                fl_grant,
  input wire logic                fl_deny,
  input wire nvmp_pkg::nvmp_sec_e fl_section,
  input wire logic [7:0]          flash_word_in_page,
  input wire logic [9:0]          flash_page_number,
  // Protection state
  input wire logic                chip_erase_req,
  input wire logic [7:0]          fuse_value,
  input wire logic [5:0]          lock_value,
  input wire logic                eeprom_mapped,
  // Data decode
  input wire logic                dm_valid,
  input wire logic                dm_write,
  input wire logic [15:0]         dm_addr,
  input wire logic [3:0]          dm_region,
  input wire logic [4:0]          eeprom_byte_in_page,
  input wire logic [6:0]          eeprom_page_number,
  input wire logic                dm_write_dropped
);
  import nvmp_pkg::*;
  logic [18:0] z_q;
  logic [15:0] da_q;
  nvmp_sec_e   sec_exp;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk) begin
    z_q <= fl_z_ptr;
    da_q <= dm_addr;
  end
  assign sec_exp = (z_q[18:1] <= 18'h1_EFFF) ? NVMP_SEC_APP :
                   (z_q[18:1] <= 18'h1_FFFF) ? NVMP_SEC_TBL :
                   (z_q[18:1] <= 18'h2_0FFF) ? NVMP_SEC_BOOT : NVMP_SEC_NONE;
  property p_one_answer; fl_req_valid |=> fl_grant != fl_deny; endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("No single flash answer.");
  property p_quiet; !fl_req_valid |=> !fl_grant && !fl_deny; endproperty
  a_quiet: assert property (p_quiet)
    else $error("Answer without request.");
  property p_boot_only;
    fl_req_valid && fl_req_write && !ext_prog_active &&
    (fl_exec_pc < 18'h2_0000 || fl_exec_pc > 18'h2_0FFF) |=> fl_deny;
  endproperty
  a_boot_only: assert property (p_boot_only)
    else $error("Self-write outside boot.");
  property p_section; fl_req_valid |=> fl_section == sec_exp; endproperty
  a_section: assert property (p_section)
    else $error("Section decode wrong.");
  property p_split;
    fl_req_valid |=> flash_word_in_page == z_q[8:1] && flash_page_number == z_q[18:9];
  endproperty
  a_split: assert property (p_split)
    else $error("Pointer split wrong.");
  property p_lock_up;
    (lock_value & ~$past(lock_value)) != 6'h00 |-> $past(chip_erase_req) || $past(chip_erase_req, 2);
  endproperty
  a_lock_up: assert property (p_lock_up)
    else $error("Lock relaxed.");
  property p_erase_hold; chip_erase_req && $past(chip_erase_req) |-> $stable(lock_value); endproperty
  a_erase_hold: assert property (p_erase_hold)
    else $error("Lock changed in erase.");
  property p_fuse_prog; !$stable(fuse_value) |-> $past(ext_prog_active); endproperty
  a_fuse_prog: assert property (p_fuse_prog)
    else $error("Fuse changed by software.");
  property p_io; dm_valid && dm_addr <= 16'h0FFF |=> dm_region == 4'h1; endproperty
  a_io: assert property (p_io)
    else $error("I/O decode wrong.");
  property p_map_base;
    dm_valid && eeprom_mapped && dm_addr[15:12] == 4'h1 |=> dm_region == 4'h2;
  endproperty
  a_map_base: assert property (p_map_base)
    else $error("EEPROM window wrong.");
  property p_eep_split;
    dm_valid |=> {eeprom_page_number, eeprom_byte_in_page} == da_q[11:0];
  endproperty
  a_eep_split: assert property (p_eep_split)
    else $error("EEPROM split wrong.");
  property p_drop;
    dm_valid && dm_write && dm_addr > 16'h5FFF |=> dm_write_dropped && dm_region == 4'h8;
  endproperty
  a_drop: assert property (p_drop)
    else $error("Write above SRAM kept.");
  c_boot_grant: cover property (fl_req_valid && fl_exec_pc[17:12] == 6'h20 ##1 fl_grant);
  c_erase_end: cover property ($fell(chip_erase_req));
  c_dropped: cover property (dm_write_dropped);
endmodule
bind nvmp_top nvmp_checker nvmp_checker_inst (.*);
`default_nettype wire

// ---- testbench/nvmp_prog_model.sv ----
// External programmer model issuing flash requests through the debug port.
`timescale 1ns/100ps
`default_nettype none
module nvmp_prog_model (
  // Clock
  input  wire logic        core_clk,
  // Commands from the bench
  input  wire logic        sel,
  input  wire logic        go,
  input  wire logic        go_write,
  input  wire logic [18:0] go_z,
  // Toward the device
  output logic             ext_prog_active,
  output logic             pg_valid,
  output logic             pg_write,
  output logic      [18:0] pg_z
);
  // Idle lines toggle so stale values never pass as a request.
  always_ff @(posedge core_clk) begin
    ext_prog_active <= sel | go;
    pg_valid <= go;
    pg_write <= go ? go_write : ~pg_write;
    pg_z <= go ? go_z : ~pg_z;
  end
endmodule
`default_nettype wire

// ---- testbench/nvmp_top_tb.sv ----
// Self-checking bench for the NVM protection core.
`timescale 1ns/100ps
`default_nettype none
module nvmp_top_tb;
  import nvmp_pkg::*;
  logic        core_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, fl_grant, fl_deny, sw_v, sw_w, sel, go, go_w;
  logic        ext, pg_v, pg_w, erq, edone, dmv, dmw, s_aw, s_w, s_ar, s_b, s_r, s_e;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp;
  logic [18:0] sw_z, go_z, pg_z;
  logic [17:0] pc;
  logic [15:0] dma, wd, cal, dl[7];
  nvmp_sec_e   sec;
  int          fails, checks_done, n;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [3:0]  fq[$];
  nvmp_top nvmp_top_inst (.core_clk, .rst_n, .clk_en(1'b1),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .ext_prog_active(ext), .fl_req_valid(sw_v | pg_v), .fl_req_write(pg_v ? pg_w : sw_w),
    .fl_z_ptr(pg_v ? pg_z : sw_z), .fl_exec_pc(pc), .fl_req_wdata(wd), .fl_grant, .fl_deny,
    .fl_section(sec), .flash_word_in_page(), .flash_page_number(), .fl_wdata(),
    .chip_erase_req(erq), .chip_erase_done(edone), .calib_value(cal), .fuse_value(),
    .lock_value(), .eeprom_mapped(), .dm_valid(dmv), .dm_write(dmw), .dm_addr(dma),
    .dm_region(), .eeprom_byte_in_page(), .eeprom_page_number(), .dm_write_dropped());
  nvmp_prog_model nvmp_prog_model_inst (.core_clk, .sel, .go, .go_write(go_w), .go_z,
    .ext_prog_active(ext), .pg_valid(pg_v), .pg_write(pg_w), .pg_z);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task chk(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("Counts: fails=%0d checks=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // All handshake and erase waits pass here, so a hang ends the run; readies are read settled.
  task step;
    @(negedge core_clk);
    {s_aw, s_w, s_ar, s_b, s_r, s_e} = {awready, wready, arready, bvalid, rvalid, erq};
    @(posedge core_clk);
    n++;
    if (n > 300) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    n = 0;
    bq.push_back(e);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      step;
      if (s_aw) awvalid <= 1'b0;
      if (s_w) wvalid <= 1'b0;
    end while (!s_b);
    bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a, input logic [33:0] e);
    @(posedge core_clk);
    n = 0;
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      step;
      if (s_ar) arvalid <= 1'b0;
    end while (!s_r);
    rready <= 1'b0;
  endtask
  // Expected answer is {grant, deny, section}.
  task fl(input logic p, input logic [17:0] wa, input logic w, input logic [17:0] xpc,
          input logic [3:0] e);
    @(posedge core_clk);
    fq.push_back(e);
    pc <= xpc;
    wd <= 16'(r);
    if (p) begin
      go_z <= {wa, 1'b0};
      go_w <= w;
      go <= 1'b1;
    end else begin
      sw_z <= {wa, 1'b0};
      sw_w <= w;
      sw_v <= 1'b1;
    end
    @(posedge core_clk);
    sw_v <= 1'b0;
    go <= 1'b0;
    @(posedge core_clk);
  endtask
  task dm(input logic [15:0] a);
    @(posedge core_clk);
    dmv <= 1'b1;
    dmw <= a[0];
    dma <= a;
    @(posedge core_clk);
    dmv <= 1'b0;
  endtask
  always @(negedge core_clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
    if (fl_grant || fl_deny) chk(34'({fl_grant, fl_deny, sec}), 34'(fq.pop_front()));
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, sw_v, sw_w, sel, go, go_w} = '0;
    {edone, dmv, dmw, awaddr, araddr, wdata, sw_z, go_z, pc, dma, wd} = '0;
    void'($urandom(32'h8c24_b9d4));
    r = $urandom;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(34'(cal), 34'h0_0000_0080);
    axr(8'h04, 34'h0_0000_003F);
    axr(8'h08, 34'h0_0000_00FF);
    axr(8'h24, 34'h2_0000_0000);
    axw(8'h24, r, 2'h2);
    axw(8'h1C, 32'h0000_0005, 2'h0);
    axw(8'h20, 32'h0000_0000, 2'h0);
    axr(8'h20, 34'h0_0000_FFFF);
    axw(8'h08, 32'h0000_0000, 2'h0);
    axr(8'h08, 34'h0_0000_00FF);
    sel <= 1'b1;
    axw(8'h08, 32'h0000_00A5, 2'h0);
    axr(8'h08, 34'h0_0000_00A5);
    sel <= 1'b0;
    axw(8'h04, 32'h0000_003B, 2'h0);
    axw(8'h04, {r[31:6], 6'h3F}, 2'h0);
    axr(8'h04, 34'h0_0000_003B);
    fl(1'b0, 18'h1_EFFF, 1'b0, 18'h0_0000, 4'h8);
    fl(1'b0, 18'h1_F000, 1'b0, 18'h0_0000, 4'h9);
    fl(1'b0, 18'h1_FFFF, 1'b1, 18'h2_0000, 4'h5);
    fl(1'b0, 18'h0_0010, 1'b1, 18'h1_EFFF, 4'h4);
    fl(1'b0, 18'h0_0010, 1'b1, 18'h2_1000, 4'h4);
    fl(1'b0, 18'h2_0FFF, 1'b1, 18'h2_0FFF, 4'hA);
    fl(1'b0, {2'h0, r[15:0]}, 1'b1, 18'h2_0000, 4'h8);
    fl(1'b0, 18'h2_1000, 1'b0, 18'h2_0000, 4'h7);
    fl(1'b1, 18'h0_0100, 1'b1, 18'h0_0000, 4'h8);
    fl(1'b1, 18'h1_F000, 1'b1, 18'h0_0000, 4'h5);
    axw(8'h14, 32'h0000_0003, 2'h0);
    axw(8'h18, 32'h0000_1234, 2'h0);
    axr(8'h18, 34'h0_0000_1234);
    axw(8'h0C, 32'h0000_0001, 2'h0);
    n = 0;
    while (!s_e) step;
    axr(8'h04, 34'h0_0000_003B);
    @(posedge core_clk);
    edone <= 1'b1;
    @(posedge core_clk);
    edone <= 1'b0;
    n = 0;
    while (s_e) step;
    axr(8'h04, 34'h0_0000_003F);
    axr(8'h18, 34'h0_0000_1234);
    axw(8'h0C, 32'h0000_0002, 2'h0);
    axr(8'h18, 34'h0_0000_FFFF);
    // Odd addresses write.
    dl = '{16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h5FFF, 16'h6001, r[15:0]};
    for (int m = 0; m < 2; m++) begin
      axw(8'h00, 32'(m), 2'h0);
      foreach (dl[i]) dm(dl[i]);
    end
    repeat (4) @(posedge core_clk);
    tally_and_finish;
  end
endmodule
`default_nettype wire
